//--- src/udr_regs.sv
// Register block of the USB device port: frame, state, address, irq mask.
// Assumes an APB master on CLK and single-cycle SIE event pulses on CLK.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module udr_regs
	import udr_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Events from the serial engine
	input  wire logic        FRAME_TOKEN_PID,
	input  wire logic        FRAME_TOKEN_PACKET_END,
	input  wire logic        SOF_CRC_ERR,
	input  wire logic [10:0] SOF_FRAME,
	input  wire logic        BUS_RESET_DONE,
	input  wire logic        SUSPEND_SEEN,
	input  wire logic        RESUME_SEEN,
	input  wire logic        WAKEUP_SEEN,
	input  wire logic        EXT_RESUME_DONE,
	input  wire logic [7:0]  EP_IRQ_IN,
	// Control to the serial engine
	output logic             REMOTE_WAKE_START,
	output logic [6:0]       FUNC_ADDR,
	output logic             FUNC_ENABLE,
	output logic             ADDRESS_STATE,
	output logic             CONFIGURED,
	output logic [7:0]       EP_RESET,
	output logic             TXV_DISABLE,
	output logic             IRQ
);

	//------------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------------
	// Ready flop, declared here since the write strobe depends on it
	logic      rdy_q;
	wire       acc      = PSEL & PENABLE;
	// Writes land only at the edge where the master sees ready
	wire       wr       = acc & PWRITE & rdy_q;
	wire       hit_ep   = (PADDR >= OFS_EP_CSR) && (PADDR < OFS_TXVC - 12'h004);
	wire       wr_state = wr && (PADDR == OFS_STATE);
	wire       wr_faddr = wr && (PADDR == OFS_FADDR);
	wire       wr_en    = wr && (PADDR == OFS_IRQ_EN);
	wire       wr_dis   = wr && (PADDR == OFS_IRQ_DIS);
	wire       wr_clr   = wr && (PADDR == OFS_IRQ_CLR);
	wire       wr_eprst = wr && (PADDR == OFS_EP_RST);
	wire       wr_txvc  = wr && (PADDR == OFS_TXVC);
	// Endpoint index from the stride, both banks share it
	wire       in_csr   = (PADDR >= OFS_EP_CSR) && (PADDR < OFS_EP_FIFO);
	wire [11:0] ep_off  = in_csr ? (PADDR - OFS_EP_CSR)
	                              : (PADDR - OFS_EP_FIFO);
	wire [2:0] ep_idx   = ep_off[4:2];
	wire       wr_csr   = wr && in_csr && (PADDR[1:0] == 2'b00);
	wire       wr_fifo  = wr && !in_csr && hit_ep && (PADDR[1:0] == 2'b00);
	wire       mapped   = (PADDR == OFS_FRAME) || (PADDR == OFS_STATE) ||
	                      (PADDR == OFS_FADDR) || (PADDR == OFS_IRQ_EN) ||
	                      (PADDR == OFS_IRQ_DIS) || (PADDR == OFS_IRQ_MASK) ||
	                      (PADDR == OFS_IRQ_PEND) || (PADDR == OFS_IRQ_CLR) ||
	                      (PADDR == OFS_EP_RST) || (PADDR == OFS_TXVC) ||
	                      (hit_ep && PADDR[1:0] == 2'b00);

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	logic [10:0] frame_q;
	logic        sof_err_q, sof_ok_q;
	logic        addr_st_q, config_q, resume_q, rwake_q;
	logic [6:0]  faddr_q;
	logic        func_en_q;
	logic [13:0] mask_q;
	logic [13:0] pend_q;
	logic [7:0]  eprst_q;
	logic        txvd_q;
	logic [31:0] csr_q [NUM_EP];
	logic [31:0] fifo_q [NUM_EP];

	//------------------------------------------------------------------
	// Frame capture
	//------------------------------------------------------------------
	// The pid clears both flags; packet end sets one of them
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			frame_q   <= 11'h000;
			sof_err_q <= 1'b0;
			sof_ok_q  <= 1'b0;
		end
		else if (FRAME_TOKEN_PACKET_END)
		begin
			frame_q   <= SOF_FRAME;
			sof_err_q <= SOF_CRC_ERR;
			sof_ok_q  <= ~SOF_CRC_ERR;
		end
		else if (FRAME_TOKEN_PID)
		begin
			sof_err_q <= 1'b0;
			sof_ok_q  <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// Device state and address
	//------------------------------------------------------------------
	wire resume_rise = wr_state & PWDATA[FLD_RESUME] & ~resume_q
	                   & rwake_q;
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			addr_st_q <= 1'b0;
			config_q  <= 1'b0;
			resume_q  <= 1'b0;
			rwake_q   <= 1'b0;
			faddr_q   <= 7'h00;
			func_en_q <= RST_FADDR[FLD_FUNC_EN];
			txvd_q    <= RST_TXVC[FLD_TXV_DIS];
			eprst_q   <= 8'h00;
		end
		else
		begin
			if (wr_state)
			begin
				addr_st_q <= addr_st_q | PWDATA[FLD_ADDR_ST];
				config_q  <= PWDATA[FLD_CONFIG];
				resume_q  <= PWDATA[FLD_RESUME];
				rwake_q   <= PWDATA[FLD_RWAKE_EN];
			end
			if (wr_faddr)
			begin
				faddr_q   <= PWDATA[6:0];
				func_en_q <= PWDATA[FLD_FUNC_EN];
			end
			if (wr_txvc)
				txvd_q <= PWDATA[FLD_TXV_DIS];
			if (wr_eprst)
				eprst_q <= PWDATA[7:0];
		end
	end

	//------------------------------------------------------------------
	// Interrupt mask and pending
	//------------------------------------------------------------------
	// Bus reset wins over software so the mask restarts clean
	wire [13:0] wmask = PWDATA[13:0] & MASK_BITS;
	wire [13:0] mask_d = BUS_RESET_DONE ? RST_MASK[13:0]
	                   : wr_en  ? (mask_q | wmask)
	                   : wr_dis ? (mask_q & ~wmask)
	                   : mask_q;
	wire [13:0] ev = {WAKEUP_SEEN, BUS_RESET_DONE, FRAME_TOKEN_PID,
	                  EXT_RESUME_DONE, RESUME_SEEN, SUSPEND_SEEN, 8'h00};
	wire [13:0] clr = wr_clr ? (PWDATA[13:0] & CLR_BITS) : 14'h0000;
	// Endpoint bits follow their status sources; events beat clears
	wire [13:0] pend_d = {(pend_q[13:8] & ~clr[13:8]) | ev[13:8], EP_IRQ_IN};
	wire [13:0] mask_eff = mask_q | 14'h1000;
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			mask_q <= RST_MASK[13:0];
			pend_q <= 14'h0000;
		end
		else
		begin
			mask_q <= mask_d;
			pend_q <= pend_d;
		end
	end

	//------------------------------------------------------------------
	// Endpoint status and fifo words
	//------------------------------------------------------------------
	// Only a status word and a fifo word per endpoint are kept here; the data path is elsewhere
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++)
		begin : g_ep
			wire sel = (ep_idx == 3'(g));
			always_ff @(posedge CLK or negedge RESET_N)
			begin
				if (!RESET_N)
				begin
					csr_q[g]  <= 32'h0000_0000;
					fifo_q[g] <= 32'h0000_0000;
				end
				else
				begin
					if (BUS_RESET_DONE)
						csr_q[g] <= 32'h0000_0000;
					else if (wr_csr && sel)
						csr_q[g] <= PWDATA;
					if (wr_fifo && sel)
						fifo_q[g] <= PWDATA;
				end
			end
		end
	endgenerate

	//------------------------------------------------------------------
	// Read mux
	//------------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (PADDR)
			OFS_FRAME:    rd_mux = {14'h0000, sof_ok_q, sof_err_q,
			                        5'h00, frame_q};
			OFS_STATE:    rd_mux = {27'h0000000, rwake_q, 1'b0, resume_q,
			                        config_q, addr_st_q};
			OFS_FADDR:    rd_mux = {23'h000000, func_en_q, 1'b0, faddr_q};
			OFS_IRQ_MASK: rd_mux = {18'h00000, mask_eff};
			OFS_IRQ_PEND: rd_mux = {18'h00000, pend_q};
			OFS_EP_RST:   rd_mux = {24'h000000, eprst_q};
			OFS_TXVC:     rd_mux = {23'h000000, txvd_q, 8'h00};
			default:      rd_mux = hit_ep ? (in_csr ? csr_q[ep_idx]
			                                        : fifo_q[ep_idx])
			                              : 32'h0000_0000;
		endcase
	end

	// Registered reply; access completes two cycles after penable rises
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rdy_q   <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			rdy_q   <= acc & ~rdy_q;
			PRDATA  <= rd_mux;
			PSLVERR <= acc & ~rdy_q & ~mapped;
		end
	end
	assign PREADY = rdy_q;

	//------------------------------------------------------------------
	// Outputs from flops
	//------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			REMOTE_WAKE_START <= 1'b0;
			IRQ               <= 1'b0;
		end
		else
		begin
			REMOTE_WAKE_START <= resume_rise & rdy_q;
			IRQ               <= |(pend_d & (mask_d | 14'h1000));
		end
	end
	assign FUNC_ADDR     = faddr_q;
	assign FUNC_ENABLE   = func_en_q;
	assign ADDRESS_STATE = addr_st_q;
	assign CONFIGURED    = config_q;
	assign EP_RESET      = eprst_q;
	assign TXV_DISABLE   = txvd_q;

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	chk_frame_capture: assert property (@(posedge CLK) disable iff (!RESET_N)
		FRAME_TOKEN_PACKET_END |=> frame_q == $past(SOF_FRAME))
		else $error("frame number not captured");
	chk_err_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
		FRAME_TOKEN_PACKET_END && SOF_CRC_ERR |=> sof_err_q && !sof_ok_q)
		else $error("error flag not set");
	chk_ok_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
		FRAME_TOKEN_PID && !FRAME_TOKEN_PACKET_END
		|=> !sof_ok_q && !sof_err_q)
		else $error("frame flags not cleared");
	chk_sof_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
		FRAME_TOKEN_PID |=> pend_q[FLD_SOF_IRQ])
		else $error("frame start status missing");
	chk_addr_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
		addr_st_q |=> addr_st_q)
		else $error("address state dropped");
	chk_mask_set: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_en && !BUS_RESET_DONE |=> (mask_q & $past(wmask)) == $past(wmask))
		else $error("enable did not set mask");
	chk_mask_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_dis && !wr_en && !BUS_RESET_DONE |=> (mask_q & $past(wmask)) == 0)
		else $error("disable did not clear mask");
	chk_busrst_mask: assert property (@(posedge CLK) disable iff (!RESET_N)
		BUS_RESET_DONE |=> mask_q == RST_MASK[13:0] && IRQ)
		else $error("bus reset did not restore mask");
	chk_irq_out: assert property (@(posedge CLK) disable iff (!RESET_N)
		IRQ == |(pend_q & mask_eff))
		else $error("interrupt output wrong");
	chk_wake_gate: assert property (@(posedge CLK) disable iff (!RESET_N)
		REMOTE_WAKE_START |-> $past(rwake_q, 1))
		else $error("wakeup without enable");
	cov_sof: cover property (@(posedge CLK)
		FRAME_TOKEN_PID ##[1:20] FRAME_TOKEN_PACKET_END);
	cov_wake: cover property (@(posedge CLK) REMOTE_WAKE_START);
	cov_irq: cover property (@(posedge CLK) $rose(IRQ));
endmodule : udr_regs
`default_nettype wire

//--- src/udr_pkg.sv
// Package for the USB device port state and interrupt register block.
// Assumes a 32-bit APB slave on one clock; SIE events arrive as pulses.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package udr_pkg;
	localparam logic [11:0] OFS_FRAME    = 12'h000;
	localparam logic [11:0] OFS_STATE    = 12'h004;
	localparam logic [11:0] OFS_FADDR    = 12'h008;
	localparam logic [11:0] OFS_IRQ_EN   = 12'h010;
	localparam logic [11:0] OFS_IRQ_DIS  = 12'h014;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
	localparam logic [11:0] OFS_IRQ_PEND = 12'h01C;
	localparam logic [11:0] OFS_IRQ_CLR  = 12'h020;
	localparam logic [11:0] OFS_EP_RST   = 12'h028;
	localparam logic [11:0] OFS_EP_CSR   = 12'h030;
	localparam logic [11:0] OFS_EP_FIFO  = 12'h050;
	localparam logic [11:0] OFS_TXVC     = 12'h074;
	localparam int          EP_STRIDE    = 4;
	localparam int          NUM_EP       = 8;
	// Field positions
	localparam int FLD_SOF_ERR   = 16;
	localparam int FLD_SOF_OK    = 17;
	localparam int FLD_ADDR_ST   = 0;
	localparam int FLD_CONFIG    = 1;
	localparam int FLD_RESUME    = 2;
	localparam int FLD_RWAKE_EN  = 4;
	localparam int FLD_FUNC_EN   = 8;
	localparam int FLD_SUSPEND   = 8;
	localparam int FLD_RESUME_IR = 9;
	localparam int FLD_EXT_RSM   = 10;
	localparam int FLD_SOF_IRQ   = 11;
	localparam int FLD_BUS_RST   = 12;
	localparam int FLD_WAKEUP    = 13;
	localparam int FLD_TXV_DIS   = 8;
	// Reset values and writable masks
	localparam logic [31:0] RST_MASK  = 32'h0000_1200;
	localparam logic [31:0] RST_FADDR = 32'h0000_0100;
	localparam logic [31:0] RST_TXVC  = 32'h0000_0100;
	localparam logic [13:0] MASK_BITS = 14'h2FFF;
	localparam logic [13:0] CLR_BITS  = 14'h3F00;
endpackage : udr_pkg

//--- verification/udr_host_model.sv
// Serial-engine side model: frame tokens, bus events, endpoint levels.
// Assumes the bench calls its tasks right after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module udr_host_model
(
	// Clock
	input  wire logic        clk,
	// Frame token events
	output logic             frame_token_pid,
	output logic             frame_token_packet_end,
	output logic             sof_crc_err,
	output logic [10:0]      sof_frame,
	// Bus state events
	output logic             bus_reset_done,
	output logic             suspend_seen,
	output logic             resume_seen,
	output logic             wakeup_seen,
	output logic             ext_resume_done,
	output logic [7:0]       ep_irq
);
	//------------------------------------------------------------
	// Idle levels
	//------------------------------------------------------------
	initial
	begin
		{frame_token_pid, frame_token_packet_end, sof_crc_err} = 3'b000;
		sof_frame = 11'h555;
		{bus_reset_done, suspend_seen, resume_seen} = 3'b000;
		{wakeup_seen, ext_resume_done} = 2'b00;
		ep_irq = 8'h00;
	end
	// Token pid alone; packet end comes in a later call
	task automatic frame_pid();
		frame_token_pid <= 1'b1;
		@(posedge clk);
		frame_token_pid <= 1'b0;
		@(posedge clk);
	endtask : frame_pid
	// Number scrambled after packet end so a stale value never looks valid
	task automatic frame_end(input logic [10:0] num, input logic bad);
		frame_token_packet_end <= 1'b1;
		sof_crc_err <= bad;
		sof_frame <= num;
		@(posedge clk);
		frame_token_packet_end <= 1'b0;
		sof_crc_err <= ~bad;
		sof_frame <= ~num;
		@(posedge clk);
	endtask : frame_end
	// One-cycle pulses: bus reset, suspend, resume, wakeup, ext resume
	task automatic bus_event(input logic [4:0] m);
		{bus_reset_done, suspend_seen, resume_seen} <= m[4:2];
		{wakeup_seen, ext_resume_done} <= m[1:0];
		@(posedge clk);
		{bus_reset_done, suspend_seen, resume_seen} <= 3'b000;
		{wakeup_seen, ext_resume_done} <= 2'b00;
		repeat (2) @(posedge clk);
	endtask : bus_event
	// Endpoint levels, given time to reach the irq output
	task automatic set_ep(input logic [7:0] v);
		ep_irq <= v;
		repeat (3) @(posedge clk);
	endtask : set_ep
endmodule : udr_host_model
`default_nettype wire

//--- verification/udr_regs_tb.sv
// Self-checking bench for the port register block over APB.
// Assumes the serial-engine model drives every event input.
`timescale 1ns/1ps
`default_nettype none
module udr_regs_tb;
	import udr_pkg::*;
	logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic        er, FRAME_TOKEN_PID, FRAME_TOKEN_PACKET_END;
	logic        SOF_CRC_ERR, BUS_RESET_DONE;
	logic        SUSPEND_SEEN, RESUME_SEEN, WAKEUP_SEEN, EXT_RESUME_DONE;
	logic [10:0] SOF_FRAME;
	logic [7:0]  EP_IRQ_IN, EP_RESET;
	logic [6:0]  FUNC_ADDR;
	logic        REMOTE_WAKE_START, FUNC_ENABLE, ADDRESS_STATE;
	logic        CONFIGURED, TXV_DISABLE, IRQ;
	int          n_errors, samples_checked, wake_n;
	//------------------------------------------------------------
	// Design and serial-engine model
	//------------------------------------------------------------
	udr_regs dut_u (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .FRAME_TOKEN_PID(FRAME_TOKEN_PID),
		.FRAME_TOKEN_PACKET_END(FRAME_TOKEN_PACKET_END),
		.SOF_CRC_ERR(SOF_CRC_ERR), .SOF_FRAME(SOF_FRAME),
		.BUS_RESET_DONE(BUS_RESET_DONE), .SUSPEND_SEEN(SUSPEND_SEEN),
		.RESUME_SEEN(RESUME_SEEN), .WAKEUP_SEEN(WAKEUP_SEEN),
		.EXT_RESUME_DONE(EXT_RESUME_DONE), .EP_IRQ_IN(EP_IRQ_IN),
		.REMOTE_WAKE_START(REMOTE_WAKE_START), .FUNC_ADDR(FUNC_ADDR),
		.FUNC_ENABLE(FUNC_ENABLE), .ADDRESS_STATE(ADDRESS_STATE),
		.CONFIGURED(CONFIGURED), .EP_RESET(EP_RESET),
		.TXV_DISABLE(TXV_DISABLE), .IRQ(IRQ));
	udr_host_model host_u (.clk(CLK),
		.frame_token_pid(FRAME_TOKEN_PID),
		.frame_token_packet_end(FRAME_TOKEN_PACKET_END),
		.sof_crc_err(SOF_CRC_ERR),
		.sof_frame(SOF_FRAME), .bus_reset_done(BUS_RESET_DONE),
		.suspend_seen(SUSPEND_SEEN), .resume_seen(RESUME_SEEN),
		.wakeup_seen(WAKEUP_SEEN), .ext_resume_done(EXT_RESUME_DONE),
		.ep_irq(EP_IRQ_IN));
	// Free-running clock
	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// Wakeup pulses counted, since they last a single cycle
	always @(posedge CLK)
		if (REMOTE_WAKE_START === 1'b1)
			wake_n++;
	//------------------------------------------------------------
	// Checking and bus tasks
	//------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic results();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// Request held until pready is seen; one idle edge keeps drives apart
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		i = 0;
		do
		begin
			@(posedge CLK);
			i++;
		end
		while (PREADY !== 1'b1 && i < 16);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
		if (i >= 16)
		begin
			n_errors++;
			$display("[ERR] %0t no bus answer", $time);
			results();
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk
	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial
	begin
		{RESET_N, PSEL, PENABLE, PWRITE} = 4'b0000;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		{n_errors, samples_checked, wake_n} = {32'd0, 32'd0, 32'd0};
		repeat (12) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		// Clock already runs before the first access
		rchk(12'h000, 32'h0000_0000);
		rchk(12'h004, 32'h0000_0000);
		rchk(12'h008, 32'h0000_0100);
		chk({FUNC_ENABLE, FUNC_ADDR}, 32'h0000_0080);
		rchk(12'h018, 32'h0000_1200);
		rchk(12'h074, 32'h0000_0100);
		chk({EP_RESET, TXV_DISABLE}, 32'h0000_0001);
		// Frame tokens: good, then bad with flags cleared at the pid
		host_u.frame_pid();
		host_u.frame_end(11'h7FF, 1'b0);
		rchk(12'h000, 32'h0002_07FF);
		wr(12'h020, 32'h0000_0800);
		host_u.frame_pid();
		rchk(12'h000, 32'h0000_07FF);
		rchk(12'h01C, 32'h0000_0800);
		chk(IRQ, 32'h0);
		host_u.frame_end(11'h123, 1'b1);
		rchk(12'h000, 32'h0001_0123);
		wr(12'h010, 32'h0000_0800);
		chk(IRQ, 32'h1);
		// Mask set and clear; bit 12 stays set
		wr(12'h010, 32'hFFFF_FFFF);
		rchk(12'h018, 32'h0000_3FFF);
		wr(12'h014, 32'h0000_18FF);
		rchk(12'h018, 32'h0000_3700);
		// Endpoint 7 words, then a bus reset restores the mask and wipes status
		wr(12'h04C, 32'h0000_00A5);
		wr(12'h06C, 32'h1234_5678);
		rchk(12'h04C, 32'h0000_00A5);
		rchk(12'h06C, 32'h1234_5678);
		host_u.bus_event(5'b10000);
		chk(IRQ, 32'h1);
		rchk(12'h018, 32'h0000_1200);
		rchk(12'h04C, 32'h0000_0000);
		rchk(12'h01C, 32'h0000_1800);
		wr(12'h020, 32'h0000_3F00);
		chk(IRQ, 32'h0);
		// Suspend masked, resume enabled from reset
		host_u.bus_event(5'b01000);
		chk(IRQ, 32'h0);
		host_u.bus_event(5'b00100);
		chk(IRQ, 32'h1);
		wr(12'h020, 32'h0000_3F00);
		// Wakeup and external resume latch but stay masked
		host_u.bus_event(5'b00011);
		rchk(12'h01C, 32'h0000_2400);
		chk(IRQ, 32'h0);
		wr(12'h020, 32'h0000_3F00);
		// Endpoint source through its mask bit
		wr(12'h010, 32'h0000_0008);
		host_u.set_ep(8'h08);
		chk(IRQ, 32'h1);
		rchk(12'h01C, 32'h0000_0008);
		wr(12'h014, 32'h0000_0008);
		chk(IRQ, 32'h0);
		host_u.set_ep(8'h00);
		// Address loaded before the address state flag
		wr(12'h008, 32'h0000_00FF);
		rchk(12'h008, 32'h0000_007F);
		chk({FUNC_ENABLE, FUNC_ADDR}, 32'h0000_007F);
		wr(12'h004, 32'h0000_0001);
		wr(12'h004, 32'h0000_0000);
		rchk(12'h004, 32'h0000_0001);
		wr(12'h004, 32'h0000_0002);
		rchk(12'h004, 32'h0000_0003);
		wr(12'h004, 32'h0000_0000);
		rchk(12'h004, 32'h0000_0001);
		chk({ADDRESS_STATE, CONFIGURED}, 32'h2);
		// Send resume: only a rise with wake enabled starts it
		wr(12'h004, 32'h0000_0011);
		wr(12'h004, 32'h0000_0015);
		wr(12'h004, 32'h0000_0015);
		chk(wake_n, 32'h1);
		wr(12'h004, 32'h0000_0001);
		wr(12'h004, 32'h0000_0005);
		chk(wake_n, 32'h1);
		// Reserved and write-only places
		rchk(12'h00C, 32'h0);
		chk(er, 32'h1);
		rchk(12'h010, 32'h0);
		chk(er, 32'h0);
		// Transceiver and endpoint reset controls reach their pins
		wr(12'h074, 32'h0000_0000);
		wr(12'h028, 32'h0000_0081);
		rchk(12'h028, 32'h0000_0081);
		chk({EP_RESET, TXV_DISABLE}, 32'h0000_0102);
		// Mid-run reset is the only way out of address state
		RESET_N <= 1'b0;
		@(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		rchk(12'h004, 32'h0000_0000);
		rchk(12'h018, 32'h0000_1200);
		results();
	end
endmodule : udr_regs_tb
`default_nettype wire
